//--- bench/sdsi_step_ctrl.sv
// Motion controller model: one step with its direction level per request.
// Assumes requests arrive only while idle, on the drive clock.
`timescale 1ns/10ps
`default_nettype none
module sdsi_step_ctrl #(
    parameter int PERIOD = 250,
    parameter int HIGH   = 120
) (
    // Clock and reset.
    input  wire logic clk_i,
    input  wire logic srst_i,
    // Request from the bench.
    input  wire logic go_i,
    input  wire logic dir_req_i,
    // Lines to the drive.
    output logic      step_o,
    output logic      dir_o,
    output logic      busy_o
);
    logic [8:0] cnt_q;
    assign busy_o = cnt_q != 9'h000;
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            cnt_q  <= 9'h000;
            step_o <= 1'b0;
            dir_o  <= 1'b0;
        end else if (cnt_q == 9'h000) begin
            step_o <= 1'b0;
            if (go_i) begin
                dir_o <= dir_req_i;
                // A 250-cycle frame keeps the rate at 500 kHz at most.
                cnt_q <= 9'(PERIOD);
            end
        end else begin
            cnt_q  <= cnt_q - 9'h001;
            // Direction settles eleven cycles before the step rises.
            step_o <= cnt_q <= 9'(PERIOD - 10) &&
                      cnt_q > 9'(PERIOD - 10 - HIGH);
        end
    end
endmodule // sdsi_step_ctrl
`default_nettype wire

//--- bench/sdsi_top_properties.sv
// Checker for the step/direction servo interface, bound to its top module.
// Assumes one clock domain and at least one count per accepted step.
`timescale 1ns/10ps
`default_nettype none
module sdsi_chk_props
    import sdsi_pkg::*;
(
    // Clock and reset.
    input wire logic        SYS_CLK_I,
    input wire logic        SRST_I,
    // Inputs watched.
    input wire logic        STEP_PULSE_IN_I,
    input wire logic        DIR_I,
    input wire logic [31:0] ENC_POS_I,
    input wire logic        BATT_LOST_I,
    input wire logic        OVERVOLT_I,
    // Outputs watched.
    input wire logic        ALARM_OUT_O,
    input wire logic        ALARM_OUT_OE_O,
    input wire logic        READY_IN_POSITION_OUT_OE_O,
    input wire logic        ZERO_INDEX_OUT_OE_O,
    input wire logic        LED_RED_O,
    input wire logic        LED_GREEN_O,
    input wire logic        MOTOR_HALT_O,
    input wire logic [31:0] TARGET_POS_O
);
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (SRST_I);
    localparam int LIM = ERR_LIMIT_CNT;
    logic               step_q;
    logic               last_dir_q;
    logic [5:0]         since_q;
    logic signed [31:0] err;
    logic               err_big;
    assign err = TARGET_POS_O - ENC_POS_I;
    assign err_big = err > LIM || err < -LIM;
    // Cycles since the last rising step edge, saturating.
    always_ff @(posedge SYS_CLK_I) begin
        step_q <= STEP_PULSE_IN_I;
        if (SRST_I) begin
            since_q    <= 6'h3f;
            last_dir_q <= 1'b0;
        end else if (STEP_PULSE_IN_I && !step_q) begin
            since_q    <= 6'h00;
            last_dir_q <= DIR_I;
        end else if (since_q != 6'h3f) begin
            since_q <= since_q + 6'h01;
        end
    end
    sequence turn_wrap;
        ($past(ENC_POS_I[14:13]) == 2'b11 && ENC_POS_I[14:13] == 2'b00) ||
        ($past(ENC_POS_I[14:13]) == 2'b00 && ENC_POS_I[14:13] == 2'b11);
    endsequence
    sequence ovv_rise;
        $rose(OVERVOLT_I);
    endsequence
    step_only_rise_a: assert property (
        $changed(TARGET_POS_O) |-> since_q <= 6'h1e)
        else $error("target moved without a recent rising step");
    dir_sense_a: assert property (
        $changed(TARGET_POS_O) |-> (last_dir_q ?
        $signed(TARGET_POS_O) > $signed($past(TARGET_POS_O)) :
        $signed(TARGET_POS_O) < $signed($past(TARGET_POS_O))))
        else $error("target moved against the direction level");
    ready_off_a: assert property (
        err_big [*3] |-> !READY_IN_POSITION_OUT_OE_O)
        else $error("in-position on with large error");
    zero_index_a: assert property (
        turn_wrap |-> ##[1:3] ZERO_INDEX_OUT_OE_O)
        else $error("zero index missed");
    selftest_red_a: assert property (
        $fell(SRST_I) |-> LED_RED_O && !LED_GREEN_O)
        else $error("lamps wrong after reset");
    alarm_pull_a: assert property (
        BATT_LOST_I [*4] |-> ALARM_OUT_OE_O && !ALARM_OUT_O)
        else $error("alarm output not pulled low");
    ovv_halt_a: assert property (
        ovv_rise |-> ##[1:4] (ALARM_OUT_OE_O && MOTOR_HALT_O))
        else $error("overvoltage did not halt");
    halt_hold_a: assert property (
        MOTOR_HALT_O [*2] |-> $stable(TARGET_POS_O))
        else $error("target moved while halted");
    batt_run_a: assert property (
        BATT_LOST_I && !OVERVOLT_I && !MOTOR_HALT_O && !err_big
        |=> !MOTOR_HALT_O)
        else $error("battery warning halted the motor");
endmodule // sdsi_chk_props
`default_nettype wire

//--- bench/sdsi_top_tb.sv
// Self-checking bench for the step/direction servo interface.
// Assumes the checker and controller model are compiled before it.
`timescale 1ns/10ps
`default_nettype none
module sdsi_top_tb;
    import sdsi_pkg::*;
    typedef struct {logic d; logic [31:0] e; logic [31:0] t;
                    logic r;} sdsi_row_s;
    logic        clk = 1'b0, srst = 1'b1, go = 1'b0, dreq = 1'b0;
    logic        batt = 1'b0, ov = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [31:0] enc = 32'h0, wdata = 32'h0, rdata, tpos;
    logic [7:0]  addr = 8'h00;
    logic        step, dir, busy, al, al_oe, rdy, rdy_oe, zi, zi_oe;
    logic        red, green, halt, irq;
    int          errors = 0, check_count = 0, run_len = 0;
    int          longs = 0, shorts = 0;
    sdsi_row_s   rows [6] = '{'{1'b1, 32'h0, 32'h4, 1'b1},
        '{1'b1, 32'h0, 32'h8, 1'b1}, '{1'b0, 32'h0, 32'h4, 1'b1},
        '{1'b0, 32'h0, 32'h0, 1'b1},
        '{1'b0, 32'hffffff9c, 32'hfffffffc, 1'b0},
        '{1'b1, 32'h0, 32'h0, 1'b1}};
    sdsi_step_ctrl i_ctrl (.clk_i(clk), .srst_i(srst), .go_i(go),
        .dir_req_i(dreq), .step_o(step), .dir_o(dir), .busy_o(busy));
    sdsi_top #(.TICK_CNT(20), .ZERO_HOLD(4)) i_dut (.SYS_CLK_I(clk),
        .SRST_I(srst), .STEP_PULSE_IN_I(step), .DIR_I(dir),
        .ENC_POS_I(enc), .BATT_LOST_I(batt), .OVERVOLT_I(ov),
        .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
        .RDATA_O(rdata), .ALARM_OUT_O(al), .ALARM_OUT_OE_O(al_oe),
        .READY_IN_POSITION_OUT_O(rdy),
        .READY_IN_POSITION_OUT_OE_O(rdy_oe), .ZERO_INDEX_OUT_O(zi),
        .ZERO_INDEX_OUT_OE_O(zi_oe), .LED_RED_O(red),
        .LED_GREEN_O(green), .MOTOR_HALT_O(halt), .TARGET_POS_O(tpos),
        .IRQ_O(irq));
    initial begin
        forever #4 clk = ~clk;
    end
    // Red run lengths: 16000 cycles is a long flash, 4000 a short one.
    always @(posedge clk) begin
        if (red === 1'b1) begin
            run_len++;
        end else begin
            if (run_len > 15990 && run_len < 16010) longs++;
            if (run_len > 3990 && run_len < 4010) shorts++;
            run_len = 0;
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check(rdata, exp);
    endtask
    task automatic stepit(input logic d);
        @(posedge clk);
        dreq <= d;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        cyc(1);
        while (busy) @(posedge clk);
        cyc(30);
    endtask
    task automatic conclude;
        $display("Checks %0d, errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #720000;
        errors++;
        conclude();
    end
    initial begin
        cyc(20);
        srst <= 1'b0;
        cyc(1);
        check(red, 32'h1);
        check(green, 32'h0);
        reg_rd(REG_GEAR_NUM, 32'h8000);
        reg_rd(REG_GEAR_DEN, 32'h2000);
        reg_rd(REG_STALL_MS, 32'h1f4);
        reg_rd(8'h30, 32'h0);
        reg_wr(REG_STALL_MS, 32'h3e8);
        reg_rd(REG_STALL_MS, 32'h3e8);
        while (green !== 1'b1) @(posedge clk);
        cyc(1);
        check(red, 32'h0);
        for (int i = 0; i < 6; i++) begin
            enc <= rows[i].e;
            stepit(rows[i].d);
            check(tpos, rows[i].t);
            check(rdy_oe, rows[i].r);
            check(rdy, 32'h0);
            reg_rd(REG_FOLLOW_ERR, rows[i].t - rows[i].e);
        end
        // Walk the single-turn field through the wrap; only the fourth step fires the index.
        for (int k = 1; k < 6; k++) begin
            enc <= (k == 5) ? 32'h0 : 32'h2000 * k;
            cyc(3);
            check(zi_oe, k == 4);
            check(zi, 32'h0);
            cyc(10);
        end
        reg_wr(REG_IRQ_ENABLE, 32'h1);
        reg_wr(REG_IRQ_CLEAR, 32'h7);
        ov <= 1'b1;
        longs = 0;
        shorts = 0;
        cyc(4);
        ov <= 1'b0;
        check(al_oe, 32'h1);
        check(halt, 32'h1);
        check(irq, 32'h1);
        reg_rd(REG_ALARM_CODE, 32'h15);
        reg_wr(REG_IRQ_ENABLE, 32'h0);
        cyc(2);
        check(irq, 32'h0);
        reg_wr(REG_IRQ_ENABLE, 32'h1);
        reg_wr(REG_IRQ_CLEAR, 32'h1);
        cyc(2);
        check(irq, 32'h0);
        cyc(62000);
        check(longs, 32'h1);
        check(shorts, 32'h5);
        reg_wr(REG_ALARM_CLEAR, 32'h1);
        cyc(3);
        check(halt, 32'h0);
        check(al_oe, 32'h0);
        batt <= 1'b1;
        cyc(5);
        reg_rd(REG_ALARM_CODE, 32'h10);
        stepit(1'b1);
        check(halt, 32'h0);
        check(tpos, 32'h4);
        // Two ticks of large error must pass before the stall alarm.
        reg_wr(REG_STALL_MS, 32'h2);
        enc <= 32'h3e8;
        cyc(15);
        check(halt, 32'h0);
        cyc(45);
        check(halt, 32'h1);
        reg_rd(REG_ALARM_CODE, 32'h14);
        enc <= 32'h4;
        reg_wr(REG_ALARM_CLEAR, 32'h1);
        cyc(3);
        check(halt, 32'h0);
        reg_wr(REG_GEAR_NUM, 32'h4);
        reg_wr(REG_GEAR_DEN, 32'h1);
        stepit(1'b0);
        check(tpos, 32'h0);
        conclude();
    end
endmodule // sdsi_top_tb
bind sdsi_top sdsi_chk_props i_chk (.SYS_CLK_I(SYS_CLK_I), .SRST_I(SRST_I),
    .STEP_PULSE_IN_I(STEP_PULSE_IN_I), .DIR_I(DIR_I),
    .ENC_POS_I(ENC_POS_I), .BATT_LOST_I(BATT_LOST_I),
    .OVERVOLT_I(OVERVOLT_I), .ALARM_OUT_O(ALARM_OUT_O),
    .ALARM_OUT_OE_O(ALARM_OUT_OE_O),
    .READY_IN_POSITION_OUT_OE_O(READY_IN_POSITION_OUT_OE_O),
    .ZERO_INDEX_OUT_OE_O(ZERO_INDEX_OUT_OE_O), .LED_RED_O(LED_RED_O),
    .LED_GREEN_O(LED_GREEN_O), .MOTOR_HALT_O(MOTOR_HALT_O),
    .TARGET_POS_O(TARGET_POS_O));
`default_nettype wire

//--- src/sdsi_gear_div.sv
// Serial restoring divider that turns one step into geared encoder counts.
// Assumes start is a one-cycle pulse and the divisor is never zero.
`timescale 1ns/10ps
`default_nettype none
module sdsi_gear_div
    import sdsi_pkg::*;
#(
    parameter int unsigned DW = 17
) (
    // Clock and reset.
    input  wire logic          clk_i,
    input  wire logic          srst_i,
    // Request.
    input  wire logic          start_i,
    input  wire logic [DW-1:0] dividend_i,
    input  wire logic [15:0]   divisor_i,
    // Result.
    output logic               done_o,
    output logic [DW-1:0]      quot_o,
    output logic [15:0]        rem_o
);
    typedef struct packed {
        logic          busy;
        logic          done;
        logic [4:0]    cnt;
        logic [DW-1:0] q;
        logic [DW-1:0] r;
    } sdsi_div_s;

    sdsi_div_s s_q, s_d;
    logic [DW-1:0] shifted;

    if (DW < 17 || DW > 31) begin : g_chk
        $error("sdsi_gear_div: DW out of range");
    end

    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        shifted = {s_q.r[DW-2:0], s_q.q[DW-1]};
        if (start_i && !s_q.busy) begin
            s_d.busy = 1'b1;
            s_d.cnt = 5'(DW);
            s_d.q = dividend_i;
            s_d.r = '0;
        end else if (s_q.busy) begin
            s_d.q = {s_q.q[DW-2:0], 1'b0};
            if (shifted >= DW'(divisor_i)) begin
                s_d.r = shifted - DW'(divisor_i);
                s_d.q[0] = 1'b1;
            end else begin
                s_d.r = shifted;
            end
            s_d.cnt = s_q.cnt - 5'h01;
            if (s_q.cnt == 5'h01) begin
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign done_o = s_q.done;
    assign quot_o = s_q.q;
    assign rem_o  = s_q.r[15:0];
endmodule // sdsi_gear_div
`default_nettype wire

//--- src/sdsi_pkg.sv
// Constants shared by the step/direction servo interface and its divider.
// Assumes a single 125 MHz clock and synchronous, active-high reset.
//
// What this block does
// - Count one step per rising step edge only.
// - Direction level chooses sign of each step.
// - Alarm output conducts only while alarm active.
// - In-position on while error below half degree, after self-test and not halted.
// - Zero-index output fires at encoder turn zero.
// - Red lamp once at power-up, then green.
// - Active alarm code readable by the host.
// - Code 0x10: one long flash, keep running.
// - Codes 0x12, 0x14, 0x15 halt the motor.
// - Long flash then low-digit short flashes, repeating.
// - Stall time before alarm set by register.
// - Gear: 32768 counts over 8192 pulses default.
package sdsi_pkg;
    localparam int unsigned CLK_HZ            = 125_000_000;
    localparam int unsigned TICK_TIME_US      = 1000;
    localparam int unsigned TICK_CYCLES       = CLK_HZ / 1_000_000 * TICK_TIME_US;
    localparam int unsigned ZERO_HOLD_US      = 10;
    localparam int unsigned ZERO_HOLD_CYCLES  = CLK_HZ / 1_000_000 * ZERO_HOLD_US;
    localparam int unsigned ENC_COUNTS_TURN   = 32768;
    localparam int unsigned ERR_LIMIT_MDEG    = 500;
    localparam int unsigned ERR_LIMIT_CNT     =
        ENC_COUNTS_TURN * ERR_LIMIT_MDEG / 360000;
    localparam logic [15:0] GEAR_NUM_RST      = 16'h8000;
    localparam logic [15:0] GEAR_DEN_RST      = 16'h2000;
    localparam logic [15:0] STALL_MS_RST      = 16'h01f4;
    localparam logic [15:0] SELFTEST_MS       = 16'h01f4;
    localparam logic [15:0] LONG_MS           = 16'h0320;
    localparam logic [15:0] SHORT_MS          = 16'h00c8;
    localparam logic [15:0] PAUSE_MS          = 16'h03e8;
    localparam logic [7:0]  REG_GEAR_NUM      = 8'h00;
    localparam logic [7:0]  REG_GEAR_DEN      = 8'h04;
    localparam logic [7:0]  REG_STALL_MS      = 8'h08;
    localparam logic [7:0]  REG_ALARM_CODE    = 8'h0c;
    localparam logic [7:0]  REG_FOLLOW_ERR    = 8'h10;
    localparam logic [7:0]  REG_IRQ_STATUS    = 8'h14;
    localparam logic [7:0]  REG_IRQ_CLEAR     = 8'h18;
    localparam logic [7:0]  REG_IRQ_ENABLE    = 8'h1c;
    localparam logic [7:0]  REG_ALARM_CLEAR   = 8'h20;
    localparam logic [7:0]  REG_TARGET_POS    = 8'h24;
    localparam logic [7:0]  ALM_NONE          = 8'h00;
    localparam logic [7:0]  ALM_BATTERY       = 8'h10;
    localparam logic [7:0]  ALM_OVERFLOW      = 8'h12;
    localparam logic [7:0]  ALM_STALL         = 8'h14;
    localparam logic [7:0]  ALM_OVERVOLT      = 8'h15;
    localparam int unsigned IRQ_ALARM_BIT     = 0;
    localparam int unsigned IRQ_INPOS_BIT     = 1;
    localparam int unsigned IRQ_ZERO_BIT      = 2;
    localparam int unsigned IRQ_W             = 3;

    typedef enum logic [2:0] {
        LED_SELFTEST = 3'b000,
        LED_NORMAL   = 3'b001,
        LED_LONG     = 3'b010,
        LED_OFF      = 3'b011,
        LED_SHORT    = 3'b100,
        LED_PAUSE    = 3'b101
    } sdsi_led_e;
endpackage

//--- src/sdsi_top.sv
// Step/direction command front end, alarms, lamps and register port.
// Assumes step, direction and encoder inputs are synchronous to the clock.
`timescale 1ns/10ps
`default_nettype none
module sdsi_top
    import sdsi_pkg::*;
#(
    parameter int unsigned TICK_CNT  = TICK_CYCLES,
    parameter int unsigned ZERO_HOLD = ZERO_HOLD_CYCLES
) (
    // Clock and reset.
    input  wire logic        SYS_CLK_I,
    input  wire logic        SRST_I,
    // Command inputs from the motion controller.
    input  wire logic        STEP_PULSE_IN_I,
    input  wire logic        DIR_I,
    // Feedback and fault sources.
    input  wire logic [31:0] ENC_POS_I,
    input  wire logic        BATT_LOST_I,
    input  wire logic        OVERVOLT_I,
    // Register port.
    input  wire logic [7:0]  ADDR_I,
    input  wire logic [31:0] WDATA_I,
    input  wire logic        WR_I,
    input  wire logic        RD_I,
    output logic [31:0]      RDATA_O,
    // Open-collector outputs, pulled to output_common when enabled.
    output logic             ALARM_OUT_O,
    output logic             ALARM_OUT_OE_O,
    output logic             READY_IN_POSITION_OUT_O,
    output logic             READY_IN_POSITION_OUT_OE_O,
    output logic             ZERO_INDEX_OUT_O,
    output logic             ZERO_INDEX_OUT_OE_O,
    // Lamps, motor control and interrupt.
    output logic             LED_RED_O,
    output logic             LED_GREEN_O,
    output logic             MOTOR_HALT_O,
    output logic [31:0]      TARGET_POS_O,
    output logic             IRQ_O
);
    localparam int unsigned DW = 17;

    typedef struct packed {
        logic               step_prev;
        logic               pend;
        logic               dir_lat;
        logic               div_run;
        logic               div_dir;
        logic [15:0]        num;
        logic [15:0]        den;
        logic [15:0]        stall_ms;
        logic [15:0]        rem;
        logic signed [31:0] target;
        logic [14:0]        enc_prev;
        logic [11:0]        zi_cnt;
        logic [16:0]        tick_cnt;
        logic               tick;
        logic [15:0]        stall_cnt;
        logic               ovf;
        logic               stall;
        logic               ovv;
        logic               inpos;
        logic [7:0]         code;
        logic [IRQ_W-1:0]   irq_stat;
        logic [IRQ_W-1:0]   irq_en;
        logic [31:0]        rdata;
        sdsi_led_e          led;
        logic [15:0]        led_ms;
        logic [3:0]         flashes;
    } sdsi_top_s;

    sdsi_top_s          s_q, s_d;
    logic               div_start;
    logic [DW-1:0]      dividend;
    logic               div_done;
    logic [DW-1:0]      div_quot;
    logic [15:0]        div_rem;
    logic signed [31:0] err;
    logic [31:0]        err_abs;
    logic [32:0]        sum;
    logic               zero_cross;
    logic               halt;
    logic [7:0]         code_now;
    logic [IRQ_W-1:0]   irq_ev;

    if (TICK_CNT < 2 || TICK_CNT > 131072 || ZERO_HOLD < 1 ||
        ZERO_HOLD > 4095) begin : g_chk
        $error("sdsi_top: timing parameter out of range");
    end

    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        return a == r;
    endfunction

    // Backward steps use the complement remainder so the fraction stays
    // in [0, den) and geared counts never drift with direction reversals.
    assign div_start = s_q.pend && !s_q.div_run && !halt;
    assign dividend  = s_q.dir_lat
        ? DW'(s_q.num) + DW'(s_q.rem)
        : DW'(s_q.num) + DW'(s_q.den - 16'h0001 - s_q.rem);

    sdsi_gear_div #(
        .DW(DW)
    ) u_div (
        .clk_i     (SYS_CLK_I),
        .srst_i    (SRST_I),
        .start_i   (div_start),
        .dividend_i(dividend),
        .divisor_i (s_q.den),
        .done_o    (div_done),
        .quot_o    (div_quot),
        .rem_o     (div_rem)
    );

    assign err     = s_q.target - $signed(ENC_POS_I);
    assign err_abs = err[31] ? 32'(-err) : 32'(err);
    assign halt    = s_q.ovf || s_q.stall || s_q.ovv;
    assign zero_cross =
        (s_q.enc_prev[14:13] == 2'b11 && ENC_POS_I[14:13] == 2'b00) ||
        (s_q.enc_prev[14:13] == 2'b00 && ENC_POS_I[14:13] == 2'b11);

    always_comb begin
        if (s_q.ovv) begin
            code_now = ALM_OVERVOLT;
        end else if (s_q.stall) begin
            code_now = ALM_STALL;
        end else if (s_q.ovf) begin
            code_now = ALM_OVERFLOW;
        end else if (BATT_LOST_I) begin
            code_now = ALM_BATTERY;
        end else begin
            code_now = ALM_NONE;
        end
    end

    always_comb begin
        s_d = s_q;
        sum = '0;
        irq_ev = '0;
        s_d.step_prev = STEP_PULSE_IN_I;
        s_d.enc_prev = ENC_POS_I[14:0];
        // Clearing first lets an alarm raised in the same cycle survive.
        if (WR_I && hit(ADDR_I, REG_ALARM_CLEAR) && WDATA_I[0]) begin
            s_d.ovf = 1'b0;
            s_d.stall = 1'b0;
            s_d.ovv = 1'b0;
            s_d.stall_cnt = '0;
        end
        // Step acceptance: a new edge sets the pending flag even if the
        // divider takes the previous one in the same cycle.
        if (div_start) begin
            s_d.pend = 1'b0;
            s_d.div_run = 1'b1;
            s_d.div_dir = s_q.dir_lat;
        end
        if (STEP_PULSE_IN_I && !s_q.step_prev) begin
            s_d.pend = 1'b1;
            s_d.dir_lat = DIR_I;
        end
        if (div_done) begin
            s_d.div_run = 1'b0;
            if (s_q.div_dir) begin
                sum = {s_q.target[31], s_q.target} + 33'(div_quot);
                s_d.rem = div_rem;
            end else begin
                sum = {s_q.target[31], s_q.target} - 33'(div_quot);
                s_d.rem = s_q.den - 16'h0001 - div_rem;
            end
            s_d.target = sum[31:0];
            if (sum[32] != sum[31]) begin
                s_d.ovf = 1'b1;
            end
        end
        // Millisecond tick shared by stall timing and lamp patterns.
        s_d.tick = 1'b0;
        if (s_q.tick_cnt == 17'(TICK_CNT - 1)) begin
            s_d.tick_cnt = '0;
            s_d.tick = 1'b1;
        end else begin
            s_d.tick_cnt = s_q.tick_cnt + 17'h00001;
        end
        // A stall time of zero disables stall detection.
        if (err_abs <= 32'(ERR_LIMIT_CNT) || halt) begin
            s_d.stall_cnt = '0;
        end else if (s_q.tick && s_q.stall_ms != 16'h0000) begin
            if (s_q.stall_cnt >= s_q.stall_ms - 16'h0001) begin
                s_d.stall = 1'b1;
            end else begin
                s_d.stall_cnt = s_q.stall_cnt + 16'h0001;
            end
        end
        if (OVERVOLT_I) begin
            s_d.ovv = 1'b1;
        end
        if (zero_cross) begin
            s_d.zi_cnt = 12'(ZERO_HOLD);
            irq_ev[IRQ_ZERO_BIT] = 1'b1;
        end else if (s_q.zi_cnt != 12'h000) begin
            s_d.zi_cnt = s_q.zi_cnt - 12'h001;
        end
        s_d.inpos = (s_q.led != LED_SELFTEST) && !halt &&
                    (err_abs <= 32'(ERR_LIMIT_CNT));
        if (s_d.inpos && !s_q.inpos) begin
            irq_ev[IRQ_INPOS_BIT] = 1'b1;
        end
        s_d.code = code_now;
        if (code_now != ALM_NONE && code_now != s_q.code) begin
            irq_ev[IRQ_ALARM_BIT] = 1'b1;
        end
        // Lamp sequencer.
        if (s_q.tick && s_q.led_ms != 16'h0000) begin
            s_d.led_ms = s_q.led_ms - 16'h0001;
        end
        case (s_q.led)
            LED_SELFTEST: begin
                if (s_q.led_ms == 16'h0000) begin
                    s_d.led = LED_NORMAL;
                end
            end
            LED_NORMAL: begin
                if (s_q.code != ALM_NONE) begin
                    s_d.led = LED_LONG;
                    s_d.led_ms = LONG_MS;
                    s_d.flashes = s_q.code[3:0];
                end
            end
            LED_LONG: begin
                if (s_q.led_ms == 16'h0000) begin
                    s_d.led = LED_OFF;
                    s_d.led_ms = SHORT_MS;
                end
            end
            LED_OFF: begin
                if (s_q.led_ms == 16'h0000) begin
                    if (s_q.flashes != 4'h0) begin
                        s_d.led = LED_SHORT;
                        s_d.led_ms = SHORT_MS;
                    end else begin
                        s_d.led = LED_PAUSE;
                        s_d.led_ms = PAUSE_MS;
                    end
                end
            end
            LED_SHORT: begin
                if (s_q.led_ms == 16'h0000) begin
                    s_d.led = LED_OFF;
                    s_d.led_ms = SHORT_MS;
                    s_d.flashes = s_q.flashes - 4'h1;
                end
            end
            LED_PAUSE: begin
                if (s_q.led_ms == 16'h0000) begin
                    s_d.led = LED_NORMAL;
                end
            end
            default: begin
                s_d.led = LED_NORMAL;
            end
        endcase
        // Register writes.
        if (WR_I) begin
            if (hit(ADDR_I, REG_GEAR_NUM)) begin
                s_d.num = WDATA_I[15:0];
            end
            // A zero denominator cannot divide, so such writes are dropped.
            if (hit(ADDR_I, REG_GEAR_DEN) && WDATA_I[15:0] != 16'h0000) begin
                s_d.den = WDATA_I[15:0];
                s_d.rem = '0;
            end
            if (hit(ADDR_I, REG_STALL_MS)) begin
                s_d.stall_ms = WDATA_I[15:0];
            end
            if (hit(ADDR_I, REG_IRQ_ENABLE)) begin
                s_d.irq_en = WDATA_I[IRQ_W-1:0];
            end
            if (hit(ADDR_I, REG_IRQ_CLEAR)) begin
                s_d.irq_stat = s_q.irq_stat & ~WDATA_I[IRQ_W-1:0];
            end
        end
        s_d.irq_stat = s_d.irq_stat | irq_ev;
        // Register reads, answered in the following cycle.
        s_d.rdata = '0;
        if (RD_I) begin
            case (ADDR_I)
                REG_GEAR_NUM:   s_d.rdata = {16'h0000, s_q.num};
                REG_GEAR_DEN:   s_d.rdata = {16'h0000, s_q.den};
                REG_STALL_MS:   s_d.rdata = {16'h0000, s_q.stall_ms};
                REG_ALARM_CODE: s_d.rdata = {24'h000000, s_q.code};
                REG_FOLLOW_ERR: s_d.rdata = 32'(err);
                REG_IRQ_STATUS: s_d.rdata = 32'(s_q.irq_stat);
                REG_IRQ_ENABLE: s_d.rdata = 32'(s_q.irq_en);
                REG_TARGET_POS: s_d.rdata = 32'(s_q.target);
                default:        s_d.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (SRST_I) begin
            s_q          <= '0;
            s_q.num      <= GEAR_NUM_RST;
            s_q.den      <= GEAR_DEN_RST;
            s_q.stall_ms <= STALL_MS_RST;
            s_q.led      <= LED_SELFTEST;
            s_q.led_ms   <= SELFTEST_MS;
        end else begin
            s_q <= s_d;
        end
    end

    assign RDATA_O                    = s_q.rdata;
    assign ALARM_OUT_O                = 1'b0;
    assign ALARM_OUT_OE_O             = s_q.code != ALM_NONE;
    assign READY_IN_POSITION_OUT_O    = 1'b0;
    assign READY_IN_POSITION_OUT_OE_O = s_q.inpos;
    assign ZERO_INDEX_OUT_O           = 1'b0;
    assign ZERO_INDEX_OUT_OE_O        = s_q.zi_cnt != 12'h000;
    assign LED_RED_O   = s_q.led == LED_SELFTEST || s_q.led == LED_LONG ||
                         s_q.led == LED_SHORT;
    assign LED_GREEN_O = s_q.led != LED_SELFTEST;
    assign MOTOR_HALT_O = halt;
    assign TARGET_POS_O = s_q.target;
    assign IRQ_O        = |(s_q.irq_stat & s_q.irq_en);
endmodule // sdsi_top
`default_nettype wire
